// ===== hw/seb_top.sv
`timescale 1ns/1ns
`default_nettype none
module seb_top
    import seb_pkg::*;
#(
    parameter logic [31:0] PRODUCT_IDENT = 32'h5345_4231
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic [15:0] req_id,
    output logic req_ready,
    input wire logic [15:0] wr_block_code,
    input wire seb_event_type events,
    input wire seb_info_type info,
    input wire seb_poll_state_type poll_state,
    input wire seb_link_state_type link_state,
    input wire logic multi_drop,
    input wire logic [3:0] dev_addr,
    output logic dev_addr_ok,
    output seb_word_type word_out
);
    // The product identification value above is arbitrary.

    typedef enum logic {
        SEB_IDLE,
        SEB_SEND
    } seb_fsm_type;

    seb_fsm_type state_q;
    logic [4:0] index_q;
    logic [SEB_NUM_CNT-1:0] inc;
    logic [SEB_WORD_W-1:0] cnt_q [SEB_NUM_CNT];
    logic [15:0] word_d;
    logic hit;

    assign inc[SEB_CNT_SCAN] = events.scan_done;
    assign inc[SEB_CNT_RD] = events.rd_blk_sent;
    assign inc[SEB_CNT_WR] = events.wr_blk_rcvd;
    assign inc[SEB_CNT_PARSE] = events.parse_ok;
    assign inc[SEB_CNT_CMD] = events.cmd_blk & events.cmd_en_dis;
    assign inc[SEB_CNT_ERR] = events.blk_err;

    // Each counter wraps through zero naturally at its full width.
    genvar g;
    generate
        for (g = 0; g < SEB_NUM_CNT; g++) begin : g_cnt
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_q[g] <= SEB_CNT_RESET;
                end else if (inc[g]) begin
                    cnt_q[g] <= cnt_q[g] + 16'h0001;
                end
            end
        end
    endgenerate

    assign req_ready = (state_q == SEB_IDLE);
    assign hit = req_valid && req_ready &&
        (req_id == SEB_REQ_ID_ZERO || req_id == SEB_REQ_ID_NEG);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SEB_IDLE;
            index_q <= SEB_OFS_RSVD_A;
        end else begin
            unique case (state_q)
                SEB_IDLE: begin
                    if (hit) begin
                        state_q <= SEB_SEND;
                        index_q <= SEB_OFS_RSVD_A;
                    end
                end
                SEB_SEND: begin
                    if (index_q == SEB_OFS_LAST) begin
                        state_q <= SEB_IDLE;
                    end else begin
                        index_q <= index_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // Word selection for the current index.
    always_comb begin
        unique case (index_q)
            SEB_OFS_REQ_CODE: word_d = wr_block_code;
            SEB_OFS_SCAN: word_d = cnt_q[SEB_CNT_SCAN];
            SEB_OFS_IDENT: word_d = PRODUCT_IDENT[31:16];
            SEB_OFS_IDENT + 5'h01: word_d = PRODUCT_IDENT[15:0];
            SEB_OFS_VERSION: word_d = info.version[31:16];
            SEB_OFS_VERSION + 5'h01: word_d = info.version[15:0];
            SEB_OFS_OS_DATE: word_d = info.os_date[31:16];
            SEB_OFS_OS_DATE + 5'h01: word_d = info.os_date[15:0];
            SEB_OFS_RUN_NUM: word_d = info.run_num[31:16];
            SEB_OFS_RUN_NUM + 5'h01: word_d = info.run_num[15:0];
            SEB_OFS_RD_CNT: word_d = cnt_q[SEB_CNT_RD];
            SEB_OFS_WR_CNT: word_d = cnt_q[SEB_CNT_WR];
            SEB_OFS_PARSE_CNT: word_d = cnt_q[SEB_CNT_PARSE];
            SEB_OFS_CMD_CNT: word_d = cnt_q[SEB_CNT_CMD];
            SEB_OFS_ERR_CNT: word_d = cnt_q[SEB_CNT_ERR];
            SEB_OFS_POLL_ST: word_d = {13'h0000, poll_state};
            SEB_OFS_LINK_ST: word_d = {13'h0000, link_state};
            default: word_d = SEB_RSVD_VALUE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_out <= '0;
        end else begin
            word_out.valid <= (state_q == SEB_SEND);
            word_out.last <= (state_q == SEB_SEND) && (index_q == SEB_OFS_LAST);
            word_out.index <= index_q;
            word_out.data <= (state_q == SEB_SEND) ? word_d : SEB_RSVD_VALUE;
        end
    end

    // Address legality for the configured channel mode.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dev_addr_ok <= 1'b0;
        end else if (multi_drop) begin
            dev_addr_ok <= (dev_addr != SEB_P2P_ADDR) && (dev_addr <= SEB_MAX_DROP_ADDR);
        end else begin
            dev_addr_ok <= (dev_addr == SEB_P2P_ADDR);
        end
    end
endmodule : seb_top
`default_nettype wire

// ===== include/seb_pkg.sv
`default_nettype none
package seb_pkg;
    localparam int SEB_WORD_W = 16;
    localparam logic [15:0] SEB_REQ_ID_ZERO = 16'h0000;
    localparam logic [15:0] SEB_REQ_ID_NEG = 16'hffff;
    localparam logic [4:0] SEB_OFS_RSVD_A = 5'h00;
    localparam logic [4:0] SEB_OFS_REQ_CODE = 5'h01;
    localparam logic [4:0] SEB_OFS_SCAN = 5'h02;
    localparam logic [4:0] SEB_OFS_IDENT = 5'h03;
    localparam logic [4:0] SEB_OFS_VERSION = 5'h05;
    localparam logic [4:0] SEB_OFS_OS_DATE = 5'h07;
    localparam logic [4:0] SEB_OFS_RUN_NUM = 5'h09;
    localparam logic [4:0] SEB_OFS_RD_CNT = 5'h0b;
    localparam logic [4:0] SEB_OFS_WR_CNT = 5'h0c;
    localparam logic [4:0] SEB_OFS_PARSE_CNT = 5'h0d;
    localparam logic [4:0] SEB_OFS_RSVD_B = 5'h0e;
    localparam logic [4:0] SEB_OFS_CMD_CNT = 5'h0f;
    localparam logic [4:0] SEB_OFS_ERR_CNT = 5'h10;
    localparam logic [4:0] SEB_OFS_POLL_ST = 5'h11;
    localparam logic [4:0] SEB_OFS_LINK_ST = 5'h12;
    localparam logic [4:0] SEB_OFS_LAST = 5'h12;
    localparam logic [15:0] SEB_CNT_RESET = 16'h0000;
    localparam logic [15:0] SEB_RSVD_VALUE = 16'h0000;
    localparam logic [3:0] SEB_MAX_DROP_ADDR = 4'hf;
    localparam logic [3:0] SEB_P2P_ADDR = 4'h0;
    localparam int SEB_NUM_CNT = 6;
    localparam int SEB_CNT_SCAN = 0;
    localparam int SEB_CNT_RD = 1;
    localparam int SEB_CNT_WR = 2;
    localparam int SEB_CNT_PARSE = 3;
    localparam int SEB_CNT_CMD = 4;
    localparam int SEB_CNT_ERR = 5;

    typedef enum logic [2:0] {
        SEB_POLL_POLLING = 3'h0,
        SEB_POLL_CONFIG = 3'h1,
        SEB_POLL_DATA = 3'h2,
        SEB_POLL_USER = 3'h3,
        SEB_POLL_WAIT_UID = 3'h4
    } seb_poll_state_type;

    typedef enum logic [2:0] {
        SEB_LINK_STARTUP = 3'h0,
        SEB_LINK_IDLE = 3'h1,
        SEB_LINK_TX_PEND = 3'h2,
        SEB_LINK_TX = 3'h3,
        SEB_LINK_RX = 3'h4,
        SEB_LINK_POST_TX = 3'h5,
        SEB_LINK_IDLE_WAIT = 3'h6
    } seb_link_state_type;

    typedef struct packed {
        logic scan_done;
        logic rd_blk_sent;
        logic wr_blk_rcvd;
        logic parse_ok;
        logic cmd_blk;
        logic cmd_en_dis;
        logic blk_err;
    } seb_event_type;

    typedef struct packed {
        logic [31:0] version;
        logic [31:0] os_date;
        logic [31:0] run_num;
    } seb_info_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic [4:0] index;
        logic [15:0] data;
    } seb_word_type;
endpackage : seb_pkg
`default_nettype wire

// ===== tb/seb_host.sv
`timescale 1ns/1ns
`default_nettype none
module seb_host (
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] id,
    output logic req_valid,
    output logic [15:0] req_id
);
    // One request cycle per go pulse; outside it the id shows its inverse.
    always_ff @(posedge clk) begin
        req_valid <= go;
        req_id <= go ? id : ~id;
    end
endmodule : seb_host
`default_nettype wire

// ===== tb/seb_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module seb_top_sva
    import seb_pkg::*;
#(parameter logic [31:0] PRODUCT_IDENT = 32'h0) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic [15:0] req_id,
    input wire logic req_ready,
    input wire logic [15:0] wr_block_code,
    input wire seb_event_type events,
    input wire seb_info_type info,
    input wire seb_poll_state_type poll_state,
    input wire seb_link_state_type link_state,
    input wire logic multi_drop,
    input wire logic [3:0] dev_addr,
    input wire logic dev_addr_ok,
    input wire seb_word_type word_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic v = word_out.valid;
    wire logic [4:0] ix = word_out.index;
    wire logic [15:0] d = word_out.data;
    wire logic hit = req_id == SEB_REQ_ID_ZERO || req_id == SEB_REQ_ID_NEG;
    wire logic tk = req_valid && req_ready && hit;
    wire logic ag = multi_drop ? dev_addr != 4'h0 : dev_addr == 4'h0;
    a_block_start: assert property (tk |-> ##2 v && ix == 5'h00)
        else $error("block did not start");
    a_index_step: assert property (v && !word_out.last |=> v && ix == $past(ix) + 5'h01)
        else $error("word index did not step");
    a_code_word: assert property (v && ix == 5'h01 |-> d == $past(wr_block_code))
        else $error("requested code word wrong");
    a_ident_word: assert property (v && ix == 5'h04 |-> d == PRODUCT_IDENT[15:0] && $past(d) == PRODUCT_IDENT[31:16])
        else $error("ident words wrong");
    a_rsvd_zero: assert property (v && (ix == 5'h00 || ix == 5'h0e) |-> d == 16'h0000)
        else $error("reserved word not zero");
    a_poll_word: assert property (v && ix == 5'h11 |-> d == {13'h0, $past(poll_state)})
        else $error("poll state word wrong");
    a_link_last: assert property (v && ix == 5'h12 |-> word_out.last && d == {13'h0, $past(link_state)})
        else $error("link state word wrong");
    a_addr_check: assert property (nrst |=> dev_addr_ok == $past(ag))
        else $error("address check wrong");
    cover property (tk && req_id == SEB_REQ_ID_ZERO);
    cover property (tk && req_id == SEB_REQ_ID_NEG);
    cover property (v && word_out.last);
endmodule : seb_top_sva
bind seb_top seb_top_sva #(.PRODUCT_IDENT(PRODUCT_IDENT)) i_seb_top_sva (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req_id(req_id), .req_ready(req_ready), .wr_block_code(wr_block_code),
    .events(events), .info(info), .poll_state(poll_state), .link_state(link_state),
    .multi_drop(multi_drop), .dev_addr(dev_addr), .dev_addr_ok(dev_addr_ok), .word_out(word_out));
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import seb_pkg::*;
    localparam logic [31:0] IDENT = 32'h1234_5678; // Arbitrary value.
    logic clk = 0, nrst = 0, go = 0, md = 0, rv, rdy, ok;
    logic [3:0] addr = 0;
    logic [15:0] id = 0, code = 0, rid;
    seb_event_type ev = '0;
    seb_info_type info = '0;
    seb_poll_state_type poll = SEB_POLL_WAIT_UID;
    seb_link_state_type link = SEB_LINK_IDLE_WAIT;
    seb_word_type w;
    logic [15:0] cnt [6] = '{default: 16'h0};
    logic [21:0] q [$];
    logic [31:0] rng = 32'd26778;
    int bad_count = 0, total_checks = 0;
    always #25 clk = ~clk;
    seb_host i_seb_host (.clk(clk), .go(go), .id(id), .req_valid(rv), .req_id(rid));
    seb_top #(.PRODUCT_IDENT(IDENT)) i_seb_top (.clk(clk), .nrst(nrst), .req_valid(rv),
        .req_id(rid), .req_ready(rdy), .wr_block_code(code), .events(ev), .info(info),
        .poll_state(poll), .link_state(link), .multi_drop(md), .dev_addr(addr),
        .dev_addr_ok(ok), .word_out(w));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    task automatic check(string what, logic [21:0] seen, logic [21:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin : mon
        logic [21:0] e;
        if (w.valid === 1'b1) begin
            e = q.size() > 0 ? q.pop_front() : 22'h3fffff;
            check("word", {w.last, w.index, w.data}, e);
        end
    end
    task automatic rd_blk(logic [15:0] i, bit hit);
        logic [15:0] x [19];
        x = '{16'h0, code, cnt[0], IDENT[31:16], IDENT[15:0], info.version[31:16],
            info.version[15:0], info.os_date[31:16], info.os_date[15:0], info.run_num[31:16],
            info.run_num[15:0], cnt[1], cnt[2], cnt[3], 16'h0, cnt[4], cnt[5], 16'(poll),
            16'(link)};
        for (int k = 0; k < 19 && hit; k++) q.push_back({k == 18, 5'(k), x[k]});
        go <= 1'b1;
        id <= i;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        check("ready", 22'(rdy), 22'(!hit));
        repeat (28) @(posedge clk);
        if (q.size() != 0) begin
            bad_count++;
            finish_test();
        end
        $display("block %h done", i);
    endtask : rd_blk
    initial begin
        logic [31:0] r;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        r = xs();
        code <= r[15:0];
        info <= {xs(), xs(), xs()};
        @(posedge clk);
        rd_blk(16'h0000, 1'b1);
        repeat (40) begin
            r = xs();
            ev <= seb_event_type'(r[6:0]);
            for (int b = 0; b < 6; b++) cnt[b] += 16'(b == 4 ? r[2] & r[1] : b == 5 ? r[0] : r[6 - b]);
            @(posedge clk);
        end
        ev <= '0;
        @(posedge clk);
        rd_blk(16'hffff, 1'b1);
        rd_blk(16'h0005, 1'b0);
        for (int i = 0; i < 32; i++) begin
            {md, addr} <= i[4:0];
            repeat (2) @(posedge clk);
            check("addr ok", 22'(ok), 22'(md ? addr != 4'h0 : addr == 4'h0));
        end
        $display("addr test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
